/* File: design/dprg_pkg.sv */
// package for the dual-port ram host glue: constants and carrier structs
package dprg_pkg;

    // ----------------------------------------------------------------
    // host side decode
    // ----------------------------------------------------------------
    localparam logic [9:0] DPRG_IO_BASE_PORT = 10'h300;
    localparam logic [9:0] DPRG_IO_CTRL_PORT = 10'h301;
    localparam logic [9:0] DPRG_IO_FLAG_PORT = 10'h308;
    localparam int DPRG_FLAG_ADDR_W = 3;
    localparam int DPRG_WIN_LSB = 12;
    localparam logic [7:0] DPRG_WIN_BASE_RST = 8'h00;
    localparam int DPRG_CTRL_EN_BIT = 0;
    localparam int DPRG_CTRL_ZW_BIT = 1;
    localparam logic [1:0] DPRG_CTRL_RST = 2'h0;

    // ----------------------------------------------------------------
    // dsp side decode
    // ----------------------------------------------------------------
    localparam logic [12:0] DPRG_DSP_RAM_BASE = 13'h0000;
    localparam logic [12:0] DPRG_DSP_RAM_MASK = 13'h1000;
    localparam logic [12:0] DPRG_DSP_FLAG_BASE = 13'h1000;
    localparam logic [12:0] DPRG_DSP_FLAG_MASK = 13'h1FF8;
    localparam int DPRG_SYNC_STAGES = 2;

    typedef struct packed {
        logic ior_n;
        logic iow_n;
        logic memr_n;
        logic memw_n;
        logic [19:0] addr;
    } dprg_host_bus_t;

    typedef struct packed {
        logic ce_n;
        logic flag_select_n;
        logic read_write;
        logic oe_n;
    } dprg_ram_ctl_t;

endpackage : dprg_pkg

/* File: design/dprg_sync.sv */
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module dprg_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : dprg_sync
`default_nettype wire

/* File: design/dprg_glue.sv */
// host and dsp side control glue for a shared byte-wide dual-port ram
`timescale 1ns/1ps
`default_nettype none
module dprg_glue
    import dprg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    // host backplane
    input wire logic host_ior_n,
    input wire logic host_iow_n,
    input wire logic host_memr_n,
    input wire logic host_memw_n,
    input wire logic [19:0] host_addr,
    input wire logic [7:0] host_data,
    // host ram port controls
    output logic host_ram_ce_n,
    output logic host_flag_select_n,
    output logic host_ram_read_write,
    output logic host_ram_oe_n,
    output logic [11:0] host_ram_addr,
    output logic [7:0] window_base,
    output logic ram_enable,
    // dsp expansion bus
    input wire logic dsp_half_clock,
    input wire logic dsp_io_strobe_buffered,
    input wire logic dsp_mem_strobe,
    input wire logic dsp_xbus_read_write,
    input wire logic [12:0] dsp_xbus_addr,
    input wire logic target_io_ready,
    // dsp ram port controls
    output logic dsp_ram_ce_n,
    output logic dsp_flag_select_n,
    output logic dsp_ram_read_write,
    output logic dsp_ram_oe_n,
    output logic dsp_xbus_ready
);

    // ----------------------------------------------------------------
    // decode functions
    // ----------------------------------------------------------------
    function automatic logic dsp_in_ram(input logic [12:0] a);
        dsp_in_ram = ((a & DPRG_DSP_RAM_MASK) == DPRG_DSP_RAM_BASE);
    endfunction : dsp_in_ram

    function automatic logic dsp_in_flag(input logic [12:0] a);
        dsp_in_flag = ((a & DPRG_DSP_FLAG_MASK) == DPRG_DSP_FLAG_BASE);
    endfunction : dsp_in_flag

    function automatic logic host_flag_hit(input logic [9:0] a);
        host_flag_hit = (a[9:DPRG_FLAG_ADDR_W] == DPRG_IO_FLAG_PORT[9:DPRG_FLAG_ADDR_W]);
    endfunction : host_flag_hit

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    dprg_host_bus_t host_raw;
    dprg_host_bus_t host_s;
    logic [7:0] host_data_s;
    logic dsp_half_s;
    logic dsp_iostb_s;
    logic dsp_mstb_s;
    logic dsp_rw_s;
    logic dsp_tio_s;
    logic [12:0] dsp_addr_s;

    assign host_raw = '{ior_n: host_ior_n, iow_n: host_iow_n, memr_n: host_memr_n,
                        memw_n: host_memw_n, addr: host_addr};

    dprg_sync #(.WIDTH(24), .RST_VAL(24'hF00000)) u_sync_host (
        .clk(clk),
        .reset_n(reset_n),
        .d(host_raw),
        .q(host_s)
    );

    dprg_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_sync_hdata (
        .clk(clk),
        .reset_n(reset_n),
        .d(host_data),
        .q(host_data_s)
    );

    // idle levels after reset: strobes high, read, target not ready
    dprg_sync #(.WIDTH(18), .RST_VAL(18'h1C000)) u_sync_dsp (
        .clk(clk),
        .reset_n(reset_n),
        .d({dsp_half_clock, dsp_io_strobe_buffered, dsp_mem_strobe, dsp_xbus_read_write,
            target_io_ready, dsp_xbus_addr}),
        .q({dsp_half_s, dsp_iostb_s, dsp_mstb_s, dsp_rw_s, dsp_tio_s, dsp_addr_s})
    );

    // ----------------------------------------------------------------
    // host registers: window base and control
    // ----------------------------------------------------------------
    logic [7:0] win_base_r;
    logic [1:0] ctrl_r;
    logic iow_d_r;
    logic io_wr_rise;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            iow_d_r <= 1'b1;
        end else begin
            iow_d_r <= host_s.iow_n;
        end
    end

    // write lands as the I/O write strobe ends, when data is settled
    assign io_wr_rise = host_s.iow_n && !iow_d_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            win_base_r <= DPRG_WIN_BASE_RST;
        end else if (io_wr_rise && host_s.addr[9:0] == DPRG_IO_BASE_PORT) begin
            win_base_r <= host_data_s;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= DPRG_CTRL_RST;
        end else if (io_wr_rise && host_s.addr[9:0] == DPRG_IO_CTRL_PORT) begin
            ctrl_r <= host_data_s[1:0];
        end
    end

    // ----------------------------------------------------------------
    // host side ram controls
    // ----------------------------------------------------------------
    logic host_io_cyc;
    logic host_mem_cyc;
    logic host_win_hit;
    logic [11:0] host_addr_hold_r;
    dprg_ram_ctl_t host_nxt;
    dprg_ram_ctl_t host_r;

    assign host_io_cyc = !host_s.ior_n || !host_s.iow_n;
    assign host_mem_cyc = !host_s.memr_n || !host_s.memw_n;
    assign host_win_hit = (host_s.addr[19:DPRG_WIN_LSB] == win_base_r);

    always_comb begin
        host_nxt.read_write = host_s.iow_n && host_s.memw_n;
        host_nxt.oe_n = host_s.ior_n && host_s.memr_n;
        // array only in memory space, flags only in I/O space
        host_nxt.ce_n = !(host_mem_cyc && host_win_hit && ctrl_r[DPRG_CTRL_EN_BIT]);
        host_nxt.flag_select_n = !(host_io_cyc && !host_mem_cyc
                                   && host_flag_hit(host_s.addr[9:0]));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            host_r <= '{ce_n: 1'b1, flag_select_n: 1'b1, read_write: 1'b1, oe_n: 1'b1};
        end else begin
            host_r <= host_nxt;
        end
    end

    // address only moves while no select is active, or while read_write stays high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            host_addr_hold_r <= 12'h000;
        end else if (host_nxt.ce_n && host_nxt.flag_select_n && host_r.ce_n && host_r.flag_select_n) begin
            host_addr_hold_r <= host_s.addr[11:0];
        end else if (host_nxt.read_write && host_r.read_write && host_r.oe_n
                     && host_nxt.ce_n == host_r.ce_n) begin
            host_addr_hold_r <= host_s.addr[11:0];
        end
    end

    assign host_ram_ce_n = host_r.ce_n;
    assign host_flag_select_n = host_r.flag_select_n;
    assign host_ram_read_write = host_r.read_write;
    assign host_ram_oe_n = host_r.oe_n;
    assign host_ram_addr = host_addr_hold_r;
    assign window_base = win_base_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ram_enable <= 1'b0;
        end else begin
            ram_enable <= ctrl_r[DPRG_CTRL_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // dsp side ram controls
    // ----------------------------------------------------------------
    dprg_ram_ctl_t dsp_nxt;
    dprg_ram_ctl_t dsp_r;
    logic dsp_strobe_act;

    assign dsp_strobe_act = !dsp_iostb_s;

    always_comb begin
        dsp_nxt.read_write = dsp_rw_s;
        dsp_nxt.oe_n = !dsp_rw_s;
        // strobe gates the select, giving a ce controlled write
        dsp_nxt.ce_n = !(dsp_strobe_act && dsp_in_ram(dsp_addr_s)
                         && ctrl_r[DPRG_CTRL_EN_BIT]);
        dsp_nxt.flag_select_n = !(dsp_strobe_act && dsp_in_flag(dsp_addr_s)
                                  && ctrl_r[DPRG_CTRL_EN_BIT]);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dsp_r <= '{ce_n: 1'b1, flag_select_n: 1'b1, read_write: 1'b1, oe_n: 1'b0};
        end else begin
            dsp_r <= dsp_nxt;
        end
    end

    assign dsp_ram_ce_n = dsp_r.ce_n;
    assign dsp_flag_select_n = dsp_r.flag_select_n;
    assign dsp_ram_read_write = dsp_r.read_write;
    assign dsp_ram_oe_n = dsp_r.oe_n;

    // ----------------------------------------------------------------
    // dsp ready generation with one wait state
    // ----------------------------------------------------------------
    logic half_d_r;
    logic half_rise;
    logic strobe_cap_r;
    logic dsp_range;
    logic hold_off;
    logic ready_nxt;
    logic ready_r;

    assign half_rise = dsp_half_s && !half_d_r;
    assign dsp_range = dsp_in_ram(dsp_addr_s) || dsp_in_flag(dsp_addr_s);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            half_d_r <= 1'b0;
        end else begin
            half_d_r <= dsp_half_s;
        end
    end

    // captured strobe masks the hold-off until the strobe ends
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strobe_cap_r <= 1'b0;
        end else if (!dsp_strobe_act) begin
            strobe_cap_r <= 1'b0;
        end else if (half_rise) begin
            strobe_cap_r <= 1'b1;
        end
    end

    assign hold_off = dsp_strobe_act && dsp_range && !strobe_cap_r
                      && !ctrl_r[DPRG_CTRL_ZW_BIT];

    always_comb begin
        ready_nxt = !dsp_mstb_s || dsp_tio_s;
        if (dsp_strobe_act && !hold_off) begin
            ready_nxt = 1'b1;
        end
        if (hold_off) begin
            ready_nxt = !dsp_mstb_s || dsp_tio_s;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= ready_nxt;
        end
    end

    assign dsp_xbus_ready = ready_r;

endmodule : dprg_glue
`default_nettype wire

/* File: bench/dprg_glue_asserts.sv */
// concurrent checks on the shared ram glue ports
`timescale 1ns/1ps
`default_nettype none
module dprg_glue_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic host_ior_n,
    input wire logic host_iow_n,
    input wire logic host_memr_n,
    input wire logic host_memw_n,
    input wire logic [19:0] host_addr,
    input wire logic host_ram_ce_n,
    input wire logic host_flag_select_n,
    input wire logic host_ram_read_write,
    input wire logic host_ram_oe_n,
    input wire logic [11:0] host_ram_addr,
    input wire logic [7:0] window_base,
    input wire logic ram_enable,
    input wire logic dsp_io_strobe_buffered,
    input wire logic dsp_mem_strobe,
    input wire logic [12:0] dsp_xbus_addr,
    input wire logic dsp_xbus_read_write,
    input wire logic dsp_ram_ce_n,
    input wire logic dsp_flag_select_n,
    input wire logic dsp_ram_read_write,
    input wire logic dsp_ram_oe_n,
    input wire logic dsp_xbus_ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // depth-3 history only exists after three edges
    logic [1:0] hist_r = 2'h0;
    always_ff @(posedge clk) begin
        if (hist_r != 2'h3) begin
            hist_r <= hist_r + 2'h1;
        end
    end
    // ----------------------------------------------------------------
    // host side
    // ----------------------------------------------------------------
    a_host_rw_or: assert property (hist_r == 2'h3 |->
        host_ram_read_write == ($past(host_iow_n, 3) & $past(host_memw_n, 3)))
        else $error("host read_write does not follow write strobes");
    a_host_oe_or: assert property (hist_r == 2'h3 |->
        host_ram_oe_n == ($past(host_ior_n, 3) & $past(host_memr_n, 3)))
        else $error("host output enable does not follow read strobes");
    a_host_ce_window: assert property (!host_ram_ce_n |-> ram_enable &&
        !($past(host_memr_n, 3) && $past(host_memw_n, 3)) && $past(host_addr[19:12], 3) == window_base)
        else $error("host chip enable outside an enabled window access");
    a_host_flag_io: assert property (!host_flag_select_n |-> !($past(host_ior_n, 3) && $past(host_iow_n, 3)) &&
        $past(host_memr_n, 3) && $past(host_memw_n, 3) && $past(host_addr[9:3], 3) == 7'h61)
        else $error("host flag select outside a flag port io access");
    a_host_one_sel: assert property (host_ram_ce_n || host_flag_select_n)
        else $error("host chip enable and flag select low together");
    a_host_addr_quiet: assert property ($changed(host_ram_addr) |->
        (host_ram_read_write && $past(host_ram_read_write)) || (host_ram_ce_n && $past(host_ram_ce_n)))
        else $error("host ram address moved with read_write and chip enable low");
    // ----------------------------------------------------------------
    // dsp side
    // ----------------------------------------------------------------
    a_dsp_oe_inv: assert property (dsp_ram_oe_n == !dsp_ram_read_write)
        else $error("dsp output enable is not the inverse of read_write");
    a_dsp_rw_copy: assert property (hist_r == 2'h3 |->
        dsp_ram_read_write == $past(dsp_xbus_read_write, 3))
        else $error("dsp ram read_write does not follow the bus read_write");
    a_dsp_ce_gate: assert property (!dsp_ram_ce_n |-> ram_enable &&
        !$past(dsp_io_strobe_buffered, 3) && !$past(dsp_xbus_addr[12], 3))
        else $error("dsp chip enable without strobe and ram decode");
    a_dsp_flag_gate: assert property (!dsp_flag_select_n |-> ram_enable &&
        !$past(dsp_io_strobe_buffered, 3) && $past(dsp_xbus_addr[12:3], 3) == 10'h200)
        else $error("dsp flag select without strobe and flag decode");
    a_mem_ready: assert property (!dsp_mem_strobe [*4] |-> dsp_xbus_ready)
        else $error("memory strobe did not give ready");
endmodule : dprg_glue_asserts

bind dprg_glue dprg_glue_asserts u_chk (.clk(clk), .reset_n(reset_n), .host_ior_n(host_ior_n),
    .host_iow_n(host_iow_n), .host_memr_n(host_memr_n), .host_memw_n(host_memw_n), .host_addr(host_addr),
    .host_ram_ce_n(host_ram_ce_n), .host_flag_select_n(host_flag_select_n),
    .host_ram_read_write(host_ram_read_write), .host_ram_oe_n(host_ram_oe_n), .host_ram_addr(host_ram_addr),
    .window_base(window_base),
    .ram_enable(ram_enable), .dsp_io_strobe_buffered(dsp_io_strobe_buffered), .dsp_mem_strobe(dsp_mem_strobe),
    .dsp_xbus_addr(dsp_xbus_addr), .dsp_xbus_read_write(dsp_xbus_read_write),
    .dsp_ram_ce_n(dsp_ram_ce_n), .dsp_flag_select_n(dsp_flag_select_n),
    .dsp_ram_read_write(dsp_ram_read_write), .dsp_ram_oe_n(dsp_ram_oe_n), .dsp_xbus_ready(dsp_xbus_ready));
`default_nettype wire

/* File: bench/dprg_dsp_model.sv */
// dsp expansion bus model: free half clock and io strobe cycles
`timescale 1ns/1ps
`default_nettype none
module dprg_dsp_model (
    input wire logic clk,
    input wire logic ready,
    input wire logic ce_n,
    input wire logic flag_n,
    output logic half_clk,
    output logic strobe_n,
    output logic rw,
    output logic [12:0] addr
);
    initial begin
        strobe_n = 1'b1;
        rw = 1'b1;
        addr = 13'h1FFF;
    end
    // free running, out of phase with clk
    initial begin
        half_clk = 1'b0;
        forever #37 half_clk = ~half_clk;
    end
    // drives and samples on the falling edge, where design outputs are settled
    task automatic cycle(input logic [12:0] a, input logic w, output int waits, output logic ce_seen,
                         output logic fl_seen);
        @(negedge clk);
        addr = a;
        rw = w;
        @(negedge clk);
        strobe_n = 1'b0;
        waits = 0;
        ce_seen = 1'b0;
        fl_seen = 1'b0;
        do begin
            @(negedge clk);
            waits++;
            ce_seen |= !ce_n;
            fl_seen |= !flag_n;
        end while (ready !== 1'b1 && waits < 100);
        strobe_n = 1'b1;
        // released bus no longer shows the last address
        addr = ~a;
        rw = ~w;
    endtask : cycle
endmodule : dprg_dsp_model
`default_nettype wire

/* File: bench/dprg_testbench.sv */
// self-checking bench for the shared ram glue
`timescale 1ns/1ps
`default_nettype none
module testbench
    import dprg_pkg::*;
;
    typedef struct packed {
        logic [3:0] strb;
        logic [19:0] addr;
        logic [3:0] exp;
    } dprg_row_t;
    // strobes {ior,iow,memr,memw}; outputs {ce,flag,rw,oe}
    localparam dprg_row_t ROWS [7] = '{'{4'hD, 20'hA5123, 4'h6}, '{4'hE, 20'hA5FFF, 4'h5},
        '{4'hD, 20'hA6000, 4'hE}, '{4'h7, 20'h0030A, 4'hA}, '{4'hB, 20'h0030F, 4'h9},
        '{4'hD, 20'hA5308, 4'h6}, '{4'h7, 20'h00310, 4'hE}};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] strb = 4'hF;
    logic [19:0] haddr = 20'h0;
    logic [7:0] hdata = 8'h0;
    logic dsp_mem_strobe_n = 1'b1;
    logic tio_rdy = 1'b0;
    logic hce_n, hfl_n, hrw, hoe_n, ram_en, half, dstb_n, drw, dce_n, dfl_n, dram_rw, doe_n, drdy;
    logic [11:0] hram_addr;
    logic [7:0] wbase;
    logic [12:0] daddr;
    logic [3:0] seen;
    logic ce_s, fl_s;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int w_ram, w_out, w_zw;
    always #12.5 clk = ~clk;
    dprg_glue uut (.clk(clk), .reset_n(reset_n), .host_ior_n(strb[3]), .host_iow_n(strb[2]),
        .host_memr_n(strb[1]), .host_memw_n(strb[0]), .host_addr(haddr), .host_data(hdata),
        .host_ram_ce_n(hce_n), .host_flag_select_n(hfl_n), .host_ram_read_write(hrw), .host_ram_oe_n(hoe_n),
        .host_ram_addr(hram_addr), .window_base(wbase), .ram_enable(ram_en), .dsp_half_clock(half),
        .dsp_io_strobe_buffered(dstb_n), .dsp_mem_strobe(dsp_mem_strobe_n), .dsp_xbus_read_write(drw),
        .dsp_xbus_addr(daddr), .target_io_ready(tio_rdy), .dsp_ram_ce_n(dce_n), .dsp_flag_select_n(dfl_n),
        .dsp_ram_read_write(dram_rw), .dsp_ram_oe_n(doe_n), .dsp_xbus_ready(drdy));
    dprg_dsp_model dsp (.clk(clk), .ready(drdy), .ce_n(dce_n), .flag_n(dfl_n), .half_clk(half),
        .strobe_n(dstb_n), .rw(drw), .addr(daddr));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic host_op(input logic [3:0] s, input logic [19:0] a, input logic [7:0] d);
        @(negedge clk);
        strb = s;
        haddr = a;
        hdata = d;
        repeat (4) @(negedge clk);
        seen = {hce_n, hfl_n, hrw, hoe_n};
        strb = 4'hF;
        repeat (6) @(negedge clk);
    endtask : host_op
    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        check({wbase, ram_en, doe_n}, 10'h000);
        host_op(4'hD, 20'h00123, 8'h00);
        check(seen[3], 1'b1);
        check(hram_addr, 12'h123);
        host_op(4'hB, 20'h00300, 8'hA5);
        host_op(4'hB, 20'h00301, 8'h01);
        check({wbase, ram_en}, 9'h14B);
        foreach (ROWS[i]) begin
            host_op(ROWS[i].strb, ROWS[i].addr, 8'h00);
            check(seen, ROWS[i].exp);
        end
        dsp.cycle(13'h0010, 1'b1, w_ram, ce_s, fl_s);
        check({ce_s, fl_s}, 2'h2);
        dsp.cycle(13'h1800, 1'b1, w_out, ce_s, fl_s);
        check({ce_s, fl_s}, 2'h0);
        check({w_ram > w_out, w_ram <= w_out + 8}, 2'h3);
        dsp.cycle(13'h1003, 1'b0, w_zw, ce_s, fl_s);
        check({ce_s, fl_s}, 2'h1);
        host_op(4'hB, 20'h00301, 8'h03);
        dsp.cycle(13'h0FFF, 1'b1, w_zw, ce_s, fl_s);
        check({ce_s, w_zw < w_ram}, 2'h3);
        host_op(4'hB, 20'h00301, 8'h00);
        dsp.cycle(13'h1007, 1'b0, w_zw, ce_s, fl_s);
        check({ce_s, fl_s}, 2'h0);
        @(negedge clk);
        dsp_mem_strobe_n = 1'b0;
        repeat (4) @(negedge clk);
        check(drdy, 1'b1);
        dsp_mem_strobe_n = 1'b1;
        tio_rdy = 1'b1;
        repeat (4) @(negedge clk);
        check(drdy, 1'b1);
        tio_rdy = 1'b0;
        repeat (4) @(negedge clk);
        check(drdy, 1'b0);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
